// ---- verilog/isdp_pipeline.v ----
// Purpose: slave data pipeline buffer with its request control
// Assumes: processor strobes come from logic on clk_sys
// Notes: one access at a time; cycle done is withheld to stall
//
// Operation
// RULE_01 - pipeline words are 64 bits; one access slot takes four clocks
// RULE_02 - buffer holds 512 words; full and empty come from that count
// RULE_03 - blocking read on empty buffer stalls until data arrives
// RULE_04 - blocking write on full buffer stalls until space, then stores
// RULE_05 - non-blocking access always completes without stalling
// RULE_06 - non-blocking write when full completes and drops its data
// RULE_07 - non-blocking read when empty returns undefined data, state kept
// RULE_08 - software picks non-blocking accesses only when safe
// RULE_09 - write port is private to this slave, no arbitration needed
// RULE_10 - request control serves pipeline and eight one-bit registers
// RULE_11 - all logic runs on one system clock
// RULE_12 - processor pulls address strobe low with address valid
// RULE_13 - cycle done low marks end of access; read data valid then
// RULE_14 - data output enable low while returning read data
// RULE_15 - stall by withholding cycle done; mode from address bit
// RULE_16 - reset empties the buffer pointers
`include "isdp_regs.vh"
`timescale 1ns/1ns
`default_nettype none
module isdp_pipeline (
    // clock and reset
    input wire clk_sys,
    input wire nrst,
    // processor access
    input wire addrStrobe_n,
    input wire [`ISDP_ADDR_W-1:0] addr,
    input wire writeNotRead,
    input wire [`ISDP_DATA_W-1:0] wrData,
    output reg [`ISDP_DATA_W-1:0] rdData,
    output wire cycleDone_n,
    output wire dataTowardCpuOe_n,
    // pipeline output toward next slave, private to this slave (see RULE_09)
    output wire pipeOutValid,
    input wire pipeOutReady,
    output wire [`ISDP_DATA_W-1:0] pipeOutData,
    // status and subsystem bits
    output wire bufEmpty,
    output wire bufFull,
    output reg [`ISDP_SUB_BITS-1:0] subBits
);
// ----------------------------------------
// buffer storage
// ----------------------------------------
reg [`ISDP_DATA_W-1:0] mem [0:`ISDP_DEPTH-1];
reg [`ISDP_PTR_W-1:0] wrPtr;
reg [`ISDP_PTR_W-1:0] rdPtr;
reg [`ISDP_CNT_W-1:0] count;
reg [`ISDP_DATA_W-1:0] skid [0:1];
reg [1:0] skidCnt;
reg skidHead;
reg [1:0] state;
reg [1:0] slot;
reg isWrite;
reg isBlock;
reg isPipe;
reg [2:0] subIdx;
reg [`ISDP_DATA_W-1:0] latchData;
reg done;
reg oe;
localparam ST_IDLE = 2'h0;
localparam ST_WAIT = 2'h1;
localparam ST_DONE = 2'h2;
localparam [1:0] SLOT_LAST = `ISDP_SLOT_LAST;
assign bufEmpty = (count == {`ISDP_CNT_W{1'b0}}); // see RULE_02
assign bufFull = (count == `ISDP_FULL_COUNT); // see RULE_02
assign cycleDone_n = ~done; // see RULE_13
assign dataTowardCpuOe_n = ~oe; // see RULE_14
// ----------------------------------------
// two-entry buffer toward the next slave
// ----------------------------------------
wire skidRoom = (skidCnt != 2'h2);
wire drainMem = !bufEmpty && skidRoom;
assign pipeOutValid = (skidCnt != 2'h0);
assign pipeOutData = skid[skidHead];
wire outTake = pipeOutValid && pipeOutReady;
// ----------------------------------------
// request control
// ----------------------------------------
wire slotEnd = (slot == SLOT_LAST); // see RULE_01
wire canGo = isWrite ? (!bufFull || !isBlock) : (!bufEmpty || !isBlock); // see RULE_05
// a non-blocking write on a full buffer completes but stores nothing
wire doWrite = (state == ST_WAIT) && slotEnd && canGo && isPipe && isWrite && !bufFull; // see RULE_06
wire doRead = (state == ST_WAIT) && slotEnd && canGo && isPipe && !isWrite && !bufEmpty;
wire memPop = doRead || (drainMem && !doRead);
// reads by the processor take priority over the onward drain
wire drainNow = drainMem && !doRead;
// every process runs on the one system clock
always @(posedge clk_sys or negedge nrst) begin // see RULE_11
    if (!nrst) begin
        wrPtr <= {`ISDP_PTR_W{1'b0}}; // see RULE_16
        rdPtr <= {`ISDP_PTR_W{1'b0}}; // see RULE_16
        count <= {`ISDP_CNT_W{1'b0}};
    end else begin
        if (doWrite) begin
            mem[wrPtr] <= wrData; // see RULE_04
            wrPtr <= wrPtr + 1'b1;
        end
        if (memPop)
            rdPtr <= rdPtr + 1'b1;
        if (doWrite && !memPop)
            count <= count + 1'b1;
        else if (!doWrite && memPop)
            count <= count - 1'b1;
    end
end
always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
        skidCnt <= 2'h0;
        skidHead <= 1'b0;
    end else begin
        if (drainNow)
            skid[skidHead ^ skidCnt[0]] <= mem[rdPtr];
        if (outTake)
            skidHead <= ~skidHead;
        if (drainNow && !outTake)
            skidCnt <= skidCnt + 2'h1;
        else if (!drainNow && outTake)
            skidCnt <= skidCnt - 2'h1;
    end
end
always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
        state <= ST_IDLE;
        slot <= 2'h0;
        isWrite <= 1'b0;
        isBlock <= 1'b0;
        isPipe <= 1'b0;
        subIdx <= 3'h0;
        latchData <= {`ISDP_DATA_W{1'b0}};
        rdData <= {`ISDP_DATA_W{1'b0}};
        done <= 1'b0;
        oe <= 1'b0;
        subBits <= {`ISDP_SUB_BITS{1'b0}};
    end else begin
        case (state)
            ST_IDLE: begin
                done <= 1'b0;
                oe <= 1'b0;
                slot <= 2'h0;
                if (!addrStrobe_n) begin // see RULE_12
                    isWrite <= writeNotRead;
                    isBlock <= ~addr[`ISDP_MODE_BIT]; // see RULE_15
                    isPipe <= (addr[1:0] == `ISDP_SEL_PIPE);
                    subIdx <= addr[`ISDP_SUB_HI:`ISDP_SUB_LO];
                    latchData <= wrData;
                    state <= ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (!slotEnd)
                    slot <= slot + 2'h1; // see RULE_01
                else if (!isPipe) begin
                    // one-bit registers share the access slot
                    if (isWrite)
                        subBits[subIdx] <= latchData[0]; // see RULE_10
                    rdData <= {{(`ISDP_DATA_W-1){1'b0}}, subBits[subIdx]};
                    oe <= ~isWrite;
                    done <= 1'b1;
                    state <= ST_DONE;
                end else if (canGo) begin // see RULE_03
                    // empty non-blocking read leaves old data: undefined
                    if (!isWrite && !bufEmpty)
                        rdData <= mem[rdPtr]; // see RULE_07
                    oe <= ~isWrite; // see RULE_14
                    done <= 1'b1; // see RULE_13
                    state <= ST_DONE;
                end
            end
            ST_DONE: begin
                done <= 1'b0;
                oe <= 1'b0;
                state <= ST_IDLE;
            end
            default: begin
                state <= ST_IDLE;
            end
        endcase
    end
end
endmodule
`default_nettype wire

// ---- verilog/isdp_regs.vh ----
// Purpose: constants for the inter-slave data pipeline
// Assumes: one system clock, pipeline words of 64 bits
// Notes: included by isdp_pipeline.v
`ifndef ISDP_REGS_VH
`define ISDP_REGS_VH
`define ISDP_DATA_W 64
`define ISDP_DEPTH 512
`define ISDP_PTR_W 9
`define ISDP_CNT_W 10
`define ISDP_SLOT_CYCLES 4
// last slot count and full count at the widths of their counters
`define ISDP_SLOT_LAST 2'h3
`define ISDP_FULL_COUNT 10'h200
`define ISDP_SUB_BITS 8
// address decode of a processor access
`define ISDP_SEL_PIPE 2'h0
`define ISDP_SEL_SUB 2'h1
`define ISDP_MODE_BIT 3
`define ISDP_SUB_LO 3
`define ISDP_SUB_HI 5
`define ISDP_ADDR_W 8
`endif

// ---- sim/isdp_receiver.sv ----
// Purpose: onward stream receiver standing in for the next slave
// Assumes: bench sets stall to hold words back
// Notes: takes one word a cycle when not stalled
`timescale 1ns/1ns
`default_nettype none
module isdp_receiver (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // onward stream
    input wire logic pipeOutValid,
    output logic pipeOutReady,
    // bench control
    input wire logic stall
);
    assign pipeOutReady = nrst && !stall;
endmodule
`default_nettype wire

// ---- sim/isdp_pipeline_properties.sv ----
// Purpose: port checks of the pipeline access and stream
// Assumes: one clock, strobes only while idle
// Notes: bound to every isdp_pipeline
`timescale 1ns/1ns
`default_nettype none
module isdp_pipeline_properties (
    // clock, reset and access
    input wire logic clk_sys, nrst, addrStrobe_n, writeNotRead,
    input wire logic [7:0] addr,
    // answers and status
    input wire logic cycleDone_n, dataTowardCpuOe_n,
    input wire logic pipeOutValid, pipeOutReady, bufEmpty, bufFull
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    property p_slot; !addrStrobe_n |=> cycleDone_n [*4]; endproperty
    a_slot: assert property (p_slot) else $error("done early");
    property p_nb; !addrStrobe_n && addr == 8'h08 |-> ##5 !cycleDone_n; endproperty
    a_nb: assert property (p_nb) else $error("nonblocking late");
    property p_brd;
        !addrStrobe_n && addr == 8'h00 && !writeNotRead && bufEmpty |=> cycleDone_n [*6];
    endproperty
    a_brd: assert property (p_brd) else $error("empty read done");
    property p_nbf;
        !addrStrobe_n && addr == 8'h08 && bufFull && !pipeOutReady |=> bufFull [*5];
    endproperty
    a_nbf: assert property (p_nbf) else $error("full changed");
    property p_pulse; !cycleDone_n |=> cycleDone_n; endproperty
    a_pulse: assert property (p_pulse) else $error("done too long");
    property p_oe; !dataTowardCpuOe_n |-> !cycleDone_n; endproperty
    a_oe: assert property (p_oe) else $error("enable off done");
    property p_cap; bufFull |-> !bufEmpty; endproperty
    a_cap: assert property (p_cap) else $error("full and empty");
    property p_hold; pipeOutValid && !pipeOutReady |=> pipeOutValid; endproperty
    a_hold: assert property (p_hold) else $error("word lost");
endmodule
bind isdp_pipeline isdp_pipeline_properties u_chk (.clk_sys, .nrst, .addrStrobe_n,
    .writeNotRead, .addr, .cycleDone_n, .dataTowardCpuOe_n, .pipeOutValid,
    .pipeOutReady, .bufEmpty, .bufFull);
`default_nettype wire

// ---- sim/isdp_pipeline_tb.sv ----
// Purpose: self-checking bench of the pipeline port
// Assumes: receiver model on the onward stream
// Notes: two words sit in the onward buffer while stalled
`timescale 1ns/1ns
`default_nettype none
module isdp_pipeline_tb;
    reg clk_sys = 0, nrst = 0, addrStrobe_n = 1, writeNotRead = 0, stall = 1;
    reg [7:0] addr = 8'h00;
    reg [63:0] wrData = 64'h0;
    wire [63:0] rdData, pipeOutData;
    wire cycleDone_n, dataTowardCpuOe_n, pipeOutValid, pipeOutReady, bufEmpty, bufFull;
    wire [7:0] subBits;
    int fail_count = 0, checks_done = 0, n, c, o;
    isdp_pipeline uut (.clk_sys, .nrst, .addrStrobe_n, .addr, .writeNotRead, .wrData,
        .rdData, .cycleDone_n, .dataTowardCpuOe_n, .pipeOutValid, .pipeOutReady,
        .pipeOutData, .bufEmpty, .bufFull, .subBits);
    isdp_receiver rx (.clk_sys, .nrst, .pipeOutValid, .pipeOutReady, .stall);
    initial begin
        forever #50 clk_sys = ~clk_sys;
    end
    task wrap_up;
        $display("mismatches %0d checks %0d", fail_count, checks_done);
        if (fail_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input string s, input [63:0] e, input [63:0] v);
        checks_done++;
        if (v !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", s, e, v);
        end
    endtask
    // one access; c counts cycles from strobe to done
    task acc(input [7:0] a, input w, input [63:0] d, input int lim);
        @(posedge clk_sys) #1;
        addrStrobe_n = 0;
        addr = a;
        writeNotRead = w;
        wrData = d;
        @(posedge clk_sys) #1;
        addrStrobe_n = 1;
        c = 1;
        while (cycleDone_n !== 1'b0 && c < lim) begin
            @(posedge clk_sys) #1;
            c++;
        end
        o = dataTowardCpuOe_n;
        @(posedge clk_sys) #1;
    endtask
    task t_fill;
        n = 0;
        while (bufFull !== 1'b1 && n < 600) begin
            acc(8'h08, 1, n, 9);
            n++;
        end
        chk("fill", 514, n);
        // non-blocking only where the bench knows the buffer state
        acc(8'h08, 1, 64'hF, 9);
        chk("nbw", 5, c);
        chk("full", 1, bufFull);
        chk("outv", 1, pipeOutValid);
        chk("outd", 0, pipeOutData);
        acc(8'h00, 0, 0, 9);
        chk("rd", 2, rdData);
        chk("oe", 0, o);
    endtask
    task t_bwr;
        acc(8'h00, 1, 64'hA, 9);
        fork
            begin
                repeat (30) @(posedge clk_sys);
                #1 stall = 0;
            end
            acc(8'h00, 1, 64'hB, 60);
        join
        chk("bwr", 1, c > 25 && c < 60);
    endtask
    task t_empty;
        n = 0;
        while (bufEmpty !== 1'b1 && n < 3000) begin
            @(posedge clk_sys) #1;
            n++;
        end
        acc(8'h08, 0, 0, 9);
        chk("nbr", 5, c);
        chk("kept", 1, bufEmpty);
        acc(8'h29, 1, 1, 9);
        chk("sub", 8'h20, subBits);
    endtask
    task t_rst;
        acc(8'h00, 0, 0, 20);
        chk("stall", 20, c);
        nrst = 0;
        @(posedge clk_sys) #1;
        nrst = 1;
        chk("rst", 8'h00, subBits);
    endtask
    initial begin
        #2000000;
        fail_count++;
        wrap_up;
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        #1 nrst = 1;
        chk("empty", 1, bufEmpty);
        t_fill;
        t_bwr;
        t_empty;
        t_rst;
        wrap_up;
    end
endmodule
`default_nettype wire
